// *** include/etc_pkg.sv ***
package etc_pkg;

  localparam int unsigned CNT_WIDTH  = 32;
  localparam int unsigned SYNC_DEPTH = 2;
  localparam logic [CNT_WIDTH-1:0] CNT_RESET = 32'h0000_0000;
  localparam logic [CNT_WIDTH-1:0] CNT_MAX   = 32'hFFFF_FFFF;
  localparam int unsigned READ_LATENCY = 1;

  typedef enum logic [1:0] {
    ETC_EDGE_RISE = 2'b01,
    ETC_EDGE_FALL = 2'b10
  } etc_edge_type;

  // One read request from the controller; on demand and scan look alike
  typedef struct packed {
    logic valid;
    logic clear;
    logic scan;
  } etc_req_type;

  // Answer to one read request
  typedef struct packed {
    logic                 valid;
    logic                 scan;
    logic [CNT_WIDTH-1:0] count;
  } etc_rsp_type;

endpackage

// *** hw/etc_sync.sv ***
`timescale 1ns/100ps
module etc_sync
  import etc_pkg::*;
#(
  parameter int unsigned DEPTH = SYNC_DEPTH
) (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic [DEPTH-1:0] stage;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage <= '0;
    end else begin
      stage <= {stage[DEPTH-2:0], async_i};
    end
  end

  assign sync_o = stage[DEPTH-1];

endmodule

// *** hw/etc_totalizer.sv ***
`timescale 1ns/100ps
// What this block does
// - Keeps one unsigned 32-bit accumulator that adds one per counted pulse.
// - A setting picks rising or falling edges; only that edge counts.
// - A counted edge at the largest value wraps the accumulator to zero.
// - A plain read returns the count and leaves the accumulator untouched.
// - Read-and-clear returns and zeroes the count; a same-cycle edge stays.
module etc_totalizer
  import etc_pkg::*;
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 resetn_i,
  input  wire logic                 pulse_i,
  input  wire logic                 edge_fall_i,
  input  wire logic                 req_valid_i,
  input  wire logic                 req_clear_i,
  input  wire logic                 req_scan_i,
  output logic                      rsp_valid_o,
  output logic                      rsp_scan_o,
  output logic [CNT_WIDTH-1:0]      rsp_count_o,
  output logic [CNT_WIDTH-1:0]      live_count_o,
  output logic                      edge_fall_o
);

  logic                 pulse_sync;
  logic                 pulse_prev;
  logic                 hit;
  etc_edge_type         edge_sel;
  etc_req_type          req;
  etc_rsp_type          rsp;
  logic [CNT_WIDTH-1:0] count;
  logic [CNT_WIDTH-1:0] next_count;

  // Wraps by compare: CNT_MAX is followed by CNT_RESET, not by a dropped carry
  function automatic logic [CNT_WIDTH-1:0] inc_wrap(
    input logic [CNT_WIDTH-1:0] v
  );
    inc_wrap = (v == CNT_MAX) ? CNT_RESET : v + 32'h0000_0001;
  endfunction

  etc_sync #(
    .DEPTH     (SYNC_DEPTH)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .async_i   (pulse_i),
    .sync_o    (pulse_sync)
  );

  assign req = '{valid: req_valid_i, clear: req_clear_i, scan: req_scan_i};

  // Polarity setting is registered so a change never glitches the detector
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      edge_sel <= ETC_EDGE_RISE;
    end else begin
      edge_sel <= edge_fall_i ? ETC_EDGE_FALL : ETC_EDGE_RISE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pulse_prev <= 1'b0;
    end else begin
      pulse_prev <= pulse_sync;
    end
  end

  // Polarity switch keeps the history, so a held level is not an edge
  always_comb begin
    case (edge_sel)
      ETC_EDGE_RISE: hit = pulse_sync & ~pulse_prev;
      ETC_EDGE_FALL: hit = ~pulse_sync & pulse_prev;
      default:       hit = 1'b0;
    endcase
  end

  // A clear restarts from zero but still takes the edge of the same cycle
  always_comb begin
    next_count = count;
    if (req.valid && req.clear) begin
      next_count = hit ? 32'h0000_0001 : CNT_RESET;
    end else if (hit) begin
      next_count = inc_wrap(count);
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= CNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  // Scan and on-demand requests take the same path; scan only tags the answer
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp <= '{valid: 1'b0, scan: 1'b0, count: CNT_RESET};
    end else begin
      rsp.valid <= req.valid;
      rsp.scan  <= req.valid & req.scan;
      if (req.valid) begin
        rsp.count <= count;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      live_count_o <= CNT_RESET;
      edge_fall_o  <= 1'b0;
    end else begin
      live_count_o <= next_count;
      edge_fall_o  <= edge_fall_i;
    end
  end

  assign rsp_valid_o = rsp.valid;
  assign rsp_scan_o  = rsp.scan;
  assign rsp_count_o = rsp.count;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // Accumulator
  chk_count_step: assert property (
    !(req.valid && req.clear) && hit && count != CNT_MAX
      |=> count == $past(count) + 32'h0000_0001)
    else $error("count did not advance on a counted edge");

  chk_count_hold: assert property (
    !(req.valid && req.clear) && !hit |=> count == $past(count))
    else $error("count moved without an edge or clear");

  chk_wrap_zero: assert property (
    !(req.valid && req.clear) && hit && count == CNT_MAX
      |=> count == CNT_RESET)
    else $error("count did not wrap to zero");

  chk_clear_keeps: assert property (
    req.valid && req.clear |=> count == {31'h0, $past(hit)})
    else $error("read-and-clear lost or invented an edge");

  // Answers to the controller
  chk_read_value: assert property (
    req.valid |=> rsp.valid && rsp.count == $past(count))
    else $error("read answer wrong or late");

  chk_scan_same: assert property (
    req.valid |=> rsp.scan == $past(req.scan))
    else $error("scan tag wrong");

  chk_read_free: assert property (
    req.valid && !req.clear && !hit
      |=> count == $past(count))
    else $error("plain read disturbed the count");

  chk_live_mirror: assert property (
    live_count_o == count)
    else $error("live count does not match the accumulator");

  chk_rsp_single: assert property (
    !req.valid
      |=> !rsp_valid_o && !rsp_scan_o)
    else $error("answer without a request");

  chk_scan_plain: assert property (
    req.valid && !req.scan
      |=> !rsp_scan_o)
    else $error("on-demand read tagged as scan");

  chk_count_kept: assert property (
    !req.valid
      |=> $stable(rsp_count_o))
    else $error("answer count changed without a request");

  chk_clear_answer: assert property (
    req.valid && req.clear
      |=> rsp_count_o == $past(count))
    else $error("read-and-clear returned the wrong count");

  // Input path and polarity
  chk_rise_only: assert property (
    edge_sel == ETC_EDGE_RISE && !(req.valid && req.clear) && !pulse_sync
      |=> count == $past(count))
    else $error("rising mode counted while the input was low");

  chk_fall_only: assert property (
    edge_sel == ETC_EDGE_FALL && !(req.valid && req.clear) && pulse_sync
      |=> count == $past(count))
    else $error("falling mode counted while the input was high");

  chk_polarity_apply: assert property (
    edge_sel == ($past(edge_fall_i) ? ETC_EDGE_FALL : ETC_EDGE_RISE))
    else $error("polarity setting not applied after one cycle");

  chk_fall_echo: assert property (
    edge_fall_o == $past(edge_fall_i))
    else $error("polarity echo wrong");

  chk_sync_delay: assert property (
    $rose(pulse_sync) |-> $past(pulse_i, 2))
    else $error("synchroniser depth wrong");

  chk_sync_fall: assert property (
    $fell(pulse_sync)
      |-> !$past(pulse_i, 2))
    else $error("synchroniser depth wrong on a falling input");

  chk_prev_follows: assert property (
    pulse_prev == $past(pulse_sync))
    else $error("edge history does not follow the synchronised input");

  chk_no_double: assert property (
    hit
      |=> !hit || $changed(edge_sel))
    else $error("one input transition counted twice");

  // Main scenarios; the wrap needs a preset count, which the ports lack
  cov_wrap:      cover property (hit && count == CNT_MAX);
  cov_clear_hit: cover property (req.valid && req.clear && hit);
  cov_scan:      cover property (req.valid && req.scan);
  cov_fall:      cover property (edge_sel == ETC_EDGE_FALL && hit);
  cov_read_hit:  cover property (req.valid && !req.clear && hit);

endmodule

// *** test/etc_pulse_src.sv ***
`timescale 1ns/100ps
module etc_pulse_src (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] num_i,
  input  wire logic       go_i,
  output logic            pulse_o
);
  int left = 0;
  int ph   = 0;
  initial pulse_o = 1'b0;
  // Four cycles per level so the input flops see every edge
  always @(posedge clk_sys_i) begin
    if (go_i) begin
      left <= 2 * num_i;
      ph   <= 0;
    end else if (left > 0) begin
      ph <= ph + 1;
      if (ph == 3) begin
        pulse_o <= ~pulse_o;
        left    <= left - 1;
        ph      <= 0;
      end
    end
  end
endmodule

// *** test/etc_totalizer_tb_top.sv ***
`timescale 1ns/100ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  miscompares++; $display("Error %s exp %0h got %0h", n, e, a); end end
module etc_totalizer_tb_top import etc_pkg::*;;
  logic        clk_sys_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        edge_fall_i = 1'b0;
  logic        req_valid_i = 1'b0;
  logic        req_clear_i = 1'b0;
  logic        req_scan_i = 1'b0;
  logic        go = 1'b0;
  logic [7:0]  num = 8'h00;
  logic        pulse, rsp_valid_o, rsp_scan_o, edge_fall_o;
  logic [31:0] rsp_count_o, live_count_o, c;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  etc_pulse_src src (.clk_sys_i(clk_sys_i), .num_i(num), .go_i(go),
    .pulse_o(pulse));
  etc_totalizer dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .pulse_i(pulse), .edge_fall_i(edge_fall_i), .req_valid_i(req_valid_i),
    .req_clear_i(req_clear_i), .req_scan_i(req_scan_i),
    .rsp_valid_o(rsp_valid_o), .rsp_scan_o(rsp_scan_o),
    .rsp_count_o(rsp_count_o), .live_count_o(live_count_o),
    .edge_fall_o(edge_fall_o));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic rd(input logic cl, input logic sc);
    int i;
    i = 0;
    req_valid_i <= 1'b1;
    req_clear_i <= cl;
    req_scan_i <= sc;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    do begin
      @(negedge clk_sys_i);
      i++;
    end while (rsp_valid_o !== 1'b1 && i < 3);
    `CHK("rsp_valid", 1'b1, rsp_valid_o)
    `CHK("rsp_scan", sc, rsp_scan_o)
    c = rsp_count_o;
    @(posedge clk_sys_i);
  endtask
  task automatic start(input logic [7:0] n);
    num <= n;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
  endtask
  // Waits for the count, then checks the idle edge adds nothing
  task automatic wt(input logic [31:0] e);
    for (int i = 0; i < 300 && live_count_o !== e; i++) @(posedge clk_sys_i);
    repeat (12) @(posedge clk_sys_i);
    `CHK("live_count", e, live_count_o)
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    `CHK("reset_count", 32'h0000_0000, live_count_o)
    start(8'h03);
    wt(32'h0000_0003);
    rd(1'b0, 1'b0);
    `CHK("plain_read", 32'h0000_0003, c)
    rd(1'b0, 1'b1);
    `CHK("scan_read", 32'h0000_0003, c)
    $display("test rise and plain read done");
    rd(1'b1, 1'b0);
    `CHK("clear_read", 32'h0000_0003, c)
    rd(1'b0, 1'b0);
    `CHK("after_clear", 32'h0000_0000, c)
    $display("test read and clear done");
    edge_fall_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    `CHK("edge_fall", 1'b1, edge_fall_o)
    start(8'h02);
    wt(32'h0000_0002);
    $display("test falling edge done");
    start(8'h06);
    // Timed so the clear is taken on the edge that counts the second fall
    repeat (18) @(posedge clk_sys_i);
    rd(1'b1, 1'b1);
    `CHK("clear_mid", 32'h0000_0003, c)
    wt(32'h0000_0005);
    $display("test clear amid pulses done");
    end_sim();
  end
endmodule
